// ===== pkg/mbhp_pkg.sv
// constants and types shared by the microcontroller bus host port
package mbhp_pkg;
   localparam int LANE_W = 8;
   localparam int ADDR_W = 16;
   localparam int NUM_SEG_DEF = 8;
   localparam int TGT_W = 2;
   localparam int NUM_TGT = 3;
   localparam int PIN_W = 20;
   localparam logic [TGT_W-1:0] TGT_PRIMARY = 2'h0;
   localparam logic [TGT_W-1:0] TGT_SECONDARY = 2'h1;
   localparam logic [TGT_W-1:0] TGT_SRAM = 2'h2;
   // positions inside the synchronised pin vector
   localparam int LOW_LANE_LSB = 0;
   localparam int HIGH_LANE_LSB = 8;
   localparam int CTL_ZERO_BIT = 16;
   localparam int CTL_ONE_BIT = 17;
   localparam int CTL_TWO_BIT = 18;
   localparam int STROBE_BIT = 19;
   // reset values
   localparam logic [PIN_W-1:0] PIN_RST = 20'h70000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic [LANE_W-1:0] DATA_RST = 8'h00;
   localparam logic [2:0] CTL_RST = 3'h7;
   localparam logic HOLD_RST = 1'b1;

   typedef enum logic [1:0] {
      MODE_WR_RD,
      MODE_RW_ECLK,
      MODE_RW_DATASTB,
      MODE_FETCH_RD
   } mbhp_mode_type;

   typedef enum logic [1:0] {
      CYC_IDLE,
      CYC_READ,
      CYC_WRITE
   } mbhp_cycle_type;
endpackage : mbhp_pkg

// ===== src/mbhp_decode.sv
// segment decoder choosing one memory block from the latched host address
`timescale 1ns/10ps
module mbhp_decode
   import mbhp_pkg::*;
#(
   parameter int NUM_SEG = NUM_SEG_DEF
) (
   input wire logic [ADDR_W-1:0] addr,
   input wire logic progAccess,
   input wire logic anySpace,
   input wire logic [NUM_SEG-1:0] segEn,
   input wire logic [NUM_SEG-1:0][ADDR_W-1:0] segBase,
   input wire logic [NUM_SEG-1:0][ADDR_W-1:0] segMask,
   input wire logic [NUM_SEG-1:0][TGT_W-1:0] segTarget,
   input wire logic [NUM_SEG-1:0] segProgSpace,
   input wire logic inAppProgramming,
   input wire logic reclassToData,
   input wire logic secondaryRemoveEn,
   input wire logic updateDone,
   output logic [NUM_TGT-1:0] sel
);
   logic [NUM_SEG-1:0] segHit;

   genvar i;
   generate
      for (i = 0; i < NUM_SEG; i++) begin : g_seg
         logic isFlash;
         logic progEff;
         logic dropped;
         logic addrMatch;
         logic spaceMatch;
         assign isFlash = (segTarget[i] == TGT_PRIMARY) || (segTarget[i] == TGT_SECONDARY);
         // flash moves to data space while being updated
         assign progEff = segProgSpace[i] & ~(inAppProgramming & reclassToData & isFlash);
         // secondary bank leaves the map after the update
         assign dropped = secondaryRemoveEn & updateDone & (segTarget[i] == TGT_SECONDARY);
         // any base, any resolution the mask allows
         assign addrMatch = (addr & segMask[i]) == (segBase[i] & segMask[i]);
         assign spaceMatch = anySpace | (progAccess == progEff);
         assign segHit[i] = segEn[i] & addrMatch & spaceMatch & ~dropped;
      end
   endgenerate

   // lowest segment wins so overlapping segments stay deterministic
   always_comb begin
      sel = '0;
      for (int s = NUM_SEG - 1; s >= 0; s--) begin
         if (segHit[s] && (segTarget[s] < TGT_W'(NUM_TGT))) begin
            sel = '0;
            sel[segTarget[s]] = 1'b1;
         end
      end
   end
endmodule : mbhp_decode

// ===== src/mbhp_host_port.sv
// host side microcontroller bus port: address latch, strobe decode, read drive
`timescale 1ns/10ps
module mbhp_host_port
   import mbhp_pkg::*;
#(
   parameter int NUM_SEG = NUM_SEG_DEF
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [LANE_W-1:0] lowBusByteIn,
   output logic [LANE_W-1:0] lowBusByteOut,
   output logic lowBusByteOe,
   input wire logic [LANE_W-1:0] highBusByteIn,
   output logic [LANE_W-1:0] highBusByteOut,
   output logic highBusByteOe,
   input wire logic ctlPinZero,
   input wire logic ctlPinOne,
   input wire logic ctlPinTwo,
   input wire logic addrStrobeIn,
   input wire mbhp_mode_type busMode,
   input wire logic muxedBus,
   input wire logic strobeRising,
   input wire logic codeFetchEn,
   input wire logic [NUM_SEG-1:0] segEn,
   input wire logic [NUM_SEG-1:0][ADDR_W-1:0] segBase,
   input wire logic [NUM_SEG-1:0][ADDR_W-1:0] segMask,
   input wire logic [NUM_SEG-1:0][TGT_W-1:0] segTarget,
   input wire logic [NUM_SEG-1:0] segProgSpace,
   input wire logic inAppProgramming,
   input wire logic reclassToData,
   input wire logic secondaryRemoveEn,
   input wire logic updateDone,
   output logic [ADDR_W-1:0] memAddr,
   output logic [LANE_W-1:0] memWdata,
   output logic [NUM_TGT-1:0] memSel,
   output logic memRead,
   output logic memWrite,
   input wire logic [LANE_W-1:0] memRdata,
   output logic [ADDR_W-1:0] pldAddr,
   output logic [2:0] pldCtl,
   output logic pldGeneric,
   output logic codeFetch,
   output logic blockReset,
   output logic flashAbort
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_W-1:0] pinRaw;
   logic [PIN_W-1:0] pinS1_q;
   logic [PIN_W-1:0] pinS2_q;
   logic [PIN_W-1:0] pinS3_q;

   assign pinRaw = {addrStrobeIn, ctlPinTwo, ctlPinOne, ctlPinZero, highBusByteIn, lowBusByteIn};

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pinS1_q <= PIN_RST;
         pinS2_q <= PIN_RST;
      end else begin
         pinS1_q <= pinRaw;
         pinS2_q <= pinS1_q;
      end
   end

   // third stage keeps the lanes from the cycle before a falling latch edge
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pinS3_q <= PIN_RST;
      end else begin
         pinS3_q <= pinS2_q;
      end
   end

   logic ctlZero;
   logic ctlOne;
   logic ctlTwo;
   logic strobeNow;
   logic strobePrev;
   logic [ADDR_W-1:0] lanesNow;
   logic [ADDR_W-1:0] lanesPrev;

   assign ctlZero = pinS2_q[CTL_ZERO_BIT];
   assign ctlOne = pinS2_q[CTL_ONE_BIT];
   assign ctlTwo = pinS2_q[CTL_TWO_BIT];
   assign strobeNow = pinS2_q[STROBE_BIT];
   assign strobePrev = pinS3_q[STROBE_BIT];
   // high lane carries the upper address, low lane address or data
   assign lanesNow = pinS2_q[HIGH_LANE_LSB+LANE_W-1:LOW_LANE_LSB];
   assign lanesPrev = pinS3_q[HIGH_LANE_LSB+LANE_W-1:LOW_LANE_LSB];

   ////////////////////////////////////////////////////////////////////////
   // strobe decode per host style

   logic rdData;
   logic wrData;
   logic anySpace;
   logic progRd;
   logic readReq;
   logic writeReq;

   always_comb begin
      rdData = 1'b0;
      wrData = 1'b0;
      anySpace = 1'b0;
      case (busMode)
         MODE_WR_RD: begin
            rdData = ~ctlOne;
            wrData = ~ctlZero;
         end
         MODE_RW_ECLK: begin
            // direction qualified by the bus phase clock high
            rdData = ctlZero & ctlOne;
            wrData = ~ctlZero & ctlOne;
         end
         MODE_RW_DATASTB: begin
            rdData = ctlZero & ~ctlOne;
            wrData = ~ctlZero & ~ctlOne;
         end
         MODE_FETCH_RD: begin
            // fetch strobe is the only read, so it reaches both spaces
            rdData = ~ctlOne;
            wrData = ~ctlZero;
            anySpace = 1'b1;
         end
         default: begin
            rdData = 1'b0;
            wrData = 1'b0;
            anySpace = 1'b0;
         end
      endcase
   end

   assign progRd = codeFetchEn & ~ctlTwo;
   assign readReq = rdData | progRd;
   // a read strobe overrides a glitching write line
   assign writeReq = wrData & ~readReq;

   ////////////////////////////////////////////////////////////////////////
   // reset hold and flash abort

   logic resetHold_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         resetHold_q <= HOLD_RST;
      end else begin
         resetHold_q <= 1'b0;
      end
   end

   assign blockReset = resetHold_q;
   // abort reaches the flash engine from the first reset edge on
   assign flashAbort = resetHold_q;

   ////////////////////////////////////////////////////////////////////////
   // bus cycle state

   mbhp_cycle_type cycle_q;
   mbhp_cycle_type cycle_d;
   logic progQ_q;
   logic progAccess;
   logic [NUM_TGT-1:0] selNow;
   logic [NUM_TGT-1:0] sel_q;
   logic [ADDR_W-1:0] addr_q;

   always_comb begin
      cycle_d = cycle_q;
      case (cycle_q)
         CYC_IDLE: begin
            if (readReq) begin
               cycle_d = CYC_READ;
            end else if (writeReq) begin
               cycle_d = CYC_WRITE;
            end
         end
         CYC_READ: begin
            if (!readReq) begin
               cycle_d = CYC_IDLE;
            end
         end
         CYC_WRITE: begin
            if (!writeReq) begin
               cycle_d = CYC_IDLE;
            end
         end
         default: begin
            cycle_d = CYC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cycle_q <= CYC_IDLE;
      end else begin
         cycle_q <= cycle_d;
      end
   end

   // the space of the access is frozen at its start
   assign progAccess = (cycle_q == CYC_IDLE) ? (progRd & ~rdData) : progQ_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         progQ_q <= 1'b0;
      end else if (cycle_q == CYC_IDLE) begin
         progQ_q <= progRd & ~rdData & ~anySpace;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address latch

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         addr_q <= ADDR_RST;
      end else if (!muxedBus) begin
         // non multiplexed: address follows the lanes between cycles
         if (cycle_q == CYC_IDLE && !readReq && !writeReq) begin
            addr_q <= lanesNow;
         end
      end else if (strobeRising) begin
         if (strobeNow && !strobePrev) begin
            addr_q <= lanesNow;
         end
      end else if (!strobeNow && strobePrev) begin
         // falling latch edge: lanes of the cycle before still hold address
         addr_q <= lanesPrev;
      end
   end

   assign pldAddr = addr_q;
   assign memAddr = addr_q;

   ////////////////////////////////////////////////////////////////////////
   // decode

   mbhp_decode #(
      .NUM_SEG(NUM_SEG)
   ) u_decode (
      .addr(addr_q),
      .progAccess(progAccess),
      .anySpace(anySpace),
      .segEn(segEn),
      .segBase(segBase),
      .segMask(segMask),
      .segTarget(segTarget),
      .segProgSpace(segProgSpace),
      .inAppProgramming(inAppProgramming),
      .reclassToData(reclassToData),
      .secondaryRemoveEn(secondaryRemoveEn),
      .updateDone(updateDone),
      .sel(selNow)
   );

   // selects are latched as a cycle leaves idle and held until it returns to idle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sel_q <= '0;
      end else if (cycle_q == CYC_IDLE) begin
         sel_q <= (readReq | writeReq) ? selNow : '0;
      end
   end

   assign memSel = sel_q;

   ////////////////////////////////////////////////////////////////////////
   // memory strobes and write data

   logic memRead_q;
   logic memWrite_q;
   logic [LANE_W-1:0] wdata_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         memRead_q <= 1'b0;
      end else begin
         memRead_q <= (cycle_q == CYC_IDLE) && readReq && (|selNow);
      end
   end

   // write commits at the strobe's end, when data is surely settled
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         memWrite_q <= 1'b0;
      end else begin
         memWrite_q <= (cycle_q == CYC_WRITE) && !writeReq && (|sel_q);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wdata_q <= DATA_RST;
      end else if (cycle_q == CYC_WRITE && writeReq) begin
         wdata_q <= lanesNow[LANE_W-1:0];
      end
   end

   assign memRead = memRead_q;
   assign memWrite = memWrite_q;
   assign memWdata = wdata_q;

   ////////////////////////////////////////////////////////////////////////
   // read data drive

   logic [LANE_W-1:0] rdata_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= DATA_RST;
      end else if (cycle_q == CYC_READ) begin
         rdata_q <= memRdata;
      end
   end

   assign lowBusByteOut = rdata_q;
   // drive only for a live read that selected a block
   assign lowBusByteOe = (cycle_q == CYC_READ) && readReq && (|sel_q) && !resetHold_q;
   // upper lane only ever carries address on an 8-bit host
   assign highBusByteOut = DATA_RST;
   assign highBusByteOe = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // control pins towards the logic arrays

   logic [2:0] pldCtl_q;
   logic pldGeneric_q;
   logic codeFetch_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pldCtl_q <= CTL_RST;
      end else begin
         pldCtl_q <= {ctlTwo, ctlOne, ctlZero};
      end
   end

   // pin two is a plain array input unless it serves as fetch strobe
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pldGeneric_q <= 1'b0;
         codeFetch_q <= 1'b0;
      end else begin
         pldGeneric_q <= codeFetchEn ? 1'b0 : ctlTwo;
         codeFetch_q <= progRd;
      end
   end

   assign pldCtl = pldCtl_q;
   assign pldGeneric = pldGeneric_q;
   assign codeFetch = codeFetch_q;

endmodule : mbhp_host_port

// ===== dv/mbhp_host_port_properties.sv
// assertion checker for the host bus port, bound onto the port module
`timescale 1ns/10ps
module mbhp_port_props
   import mbhp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [LANE_W-1:0] lowBusByteOut,
   input wire logic lowBusByteOe,
   input wire logic highBusByteOe,
   input wire logic ctlPinOne,
   input wire logic ctlPinTwo,
   input wire mbhp_mode_type busMode,
   input wire logic codeFetchEn,
   input wire logic [NUM_TGT-1:0] memSel,
   input wire logic memRead,
   input wire logic memWrite,
   input wire logic [LANE_W-1:0] memRdata,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic [ADDR_W-1:0] pldAddr,
   input wire logic [2:0] pldCtl,
   input wire logic pldGeneric,
   input wire logic codeFetch,
   input wire logic blockReset,
   input wire logic flashAbort
);
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // strobes reach the logic late through the pin synchronisers
   wire rdPin = !ctlPinOne || (codeFetchEn && !ctlPinTwo);
   ////////////////////////////////////////
   oe_needs_sel_a: assert property (lowBusByteOe |-> $onehot(memSel))
      else $error("low lane driven with no block selected");
   oe_needs_read_a: assert property ((busMode == MODE_WR_RD && lowBusByteOe)
      |-> ($past(rdPin) || $past(rdPin, 2) || $past(rdPin, 3)))
      else $error("low lane driven without a read strobe");
   oe_data_a: assert property ((lowBusByteOe && $past(lowBusByteOe)) |-> lowBusByteOut == $past(memRdata))
      else $error("read data on lane differs from memory data");
   upper_idle_a: assert property (!highBusByteOe)
      else $error("upper lane driven");
   read_pulse_a: assert property (memRead |-> lowBusByteOe && $onehot(memSel) ##1 !memRead)
      else $error("read pulse without a driven read");
   write_pulse_a: assert property (memWrite |-> !lowBusByteOe && $onehot(memSel) ##1 !memWrite)
      else $error("write pulse malformed");
   addr_forward_a: assert property (pldAddr == memAddr)
      else $error("logic array address differs from latched address");
   fetch_flag_a: assert property (codeFetch == ($past(codeFetchEn) && !pldCtl[2]))
      else $error("code fetch flag wrong");
   generic_in_a: assert property (pldGeneric == (!$past(codeFetchEn) && pldCtl[2]))
      else $error("generic input wrong");
   reset_end_a: assert property (blockReset |-> ##[1:2] !blockReset)
      else $error("block reset held after release");
   abort_same_a: assert property (flashAbort == blockReset)
      else $error("flash abort differs from block reset");
   release_abort_a: assert property ($rose(resetn) |-> flashAbort ##1 !flashAbort)
      else $error("flash abort not held over the release edge");
   ////////////////////////////////////////
   cover property (memRead);
   cover property (memWrite);
   cover property (codeFetch ##[1:20] memRead);
endmodule : mbhp_port_props

bind mbhp_host_port mbhp_port_props i_props (.clk_sys, .resetn, .lowBusByteOut, .lowBusByteOe,
   .highBusByteOe, .ctlPinOne, .ctlPinTwo, .busMode, .codeFetchEn, .memSel, .memRead, .memWrite,
   .memRdata, .memAddr, .pldAddr, .pldCtl, .pldGeneric, .codeFetch, .blockReset, .flashAbort);

// ===== dv/mbhp_host_model.sv
// model of the host microcontroller on a multiplexed bus
`timescale 1ns/10ps
module mbhp_host_model
   import mbhp_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [LANE_W-1:0] devOut,
   input wire logic devOe,
   output logic [LANE_W-1:0] lowLane,
   output logic [LANE_W-1:0] highLane,
   output logic wrN,
   output logic rdN,
   output logic fetchN,
   output logic ale
);
   logic hostOe = 1'b0;
   logic [LANE_W-1:0] hostLow = 8'h00;
   logic [LANE_W-1:0] lastLow = 8'h00;
   // a released lane toggles so a stale value never looks valid
   assign lowLane = devOe ? devOut : hostOe ? hostLow : ~lastLow;
   always @(posedge clk_sys) lastLow <= lowLane;
   initial begin
      highLane = 8'h00;
      wrN = 1'b1;
      rdN = 1'b1;
      fetchN = 1'b1;
      ale = 1'b0;
   end
   ////////////////////////////////////////
   task automatic hostCycle(input logic wr, input logic fetch, input logic [ADDR_W-1:0] a,
      input logic [LANE_W-1:0] d, output logic [LANE_W-1:0] rd);
      @(posedge clk_sys);
      hostOe <= 1'b1;
      hostLow <= a[7:0];
      highLane <= a[15:8];
      ale <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ale <= 1'b0;
      repeat (3) @(posedge clk_sys);
      hostLow <= d;
      hostOe <= wr;
      wrN <= !wr;
      rdN <= wr || fetch;
      fetchN <= !fetch;
      repeat (8) @(posedge clk_sys);
      rd = lowLane;
      wrN <= 1'b1;
      rdN <= 1'b1;
      fetchN <= 1'b1;
      // write data outlives the strobe by four clocks, more than the synchroniser depth
      repeat (4) @(posedge clk_sys);
      hostOe <= 1'b0;
   endtask : hostCycle
endmodule : mbhp_host_model

// ===== dv/mbhp_host_port_tb_top.sv
// self-checking bench for the host bus port
`timescale 1ns/10ps
module mbhp_host_port_tb_top
   import mbhp_pkg::*;
();
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [LANE_W-1:0] lowBusByteIn, highBusByteIn, lowBusByteOut, highBusByteOut, memWdata;
   logic [LANE_W-1:0] memRdata = 8'h00;
   logic lowBusByteOe, highBusByteOe, ctlPinZero, ctlPinOne, ctlPinTwo, addrStrobeIn;
   mbhp_mode_type busMode = MODE_WR_RD;
   logic muxedBus = 1'b1, strobeRising = 1'b0, codeFetchEn = 1'b1;
   logic [NUM_SEG_DEF-1:0] segEn = 8'h07, segProgSpace = 8'h01;
   logic [NUM_SEG_DEF-1:0][ADDR_W-1:0] segBase = {80'h0, 16'h8000, 16'h4000, 16'h0000};
   logic [NUM_SEG_DEF-1:0][ADDR_W-1:0] segMask = {8{16'hc000}};
   logic [NUM_SEG_DEF-1:0][TGT_W-1:0] segTarget = {10'h0, TGT_SRAM, TGT_SECONDARY, TGT_PRIMARY};
   logic inAppProgramming = 1'b0, reclassToData = 1'b0, secondaryRemoveEn = 1'b0, updateDone = 1'b0;
   logic [ADDR_W-1:0] memAddr, pldAddr;
   logic [NUM_TGT-1:0] memSel, pulseSel;
   logic memRead, memWrite, blockReset, flashAbort, codeFetch, pldGeneric;
   logic [2:0] pldCtl;
   int nMismatch = 0, totalChecks = 0, nRead, nWrite, nOe, cycles = 0;

   always #25 clk_sys = ~clk_sys;
   // stand-in memory: read data follows the address
   always @(posedge clk_sys) memRdata <= memAddr[7:0] ^ 8'h5a;

   mbhp_host_port i_dut (.clk_sys, .resetn, .lowBusByteIn, .lowBusByteOut, .lowBusByteOe, .highBusByteIn,
      .highBusByteOut, .highBusByteOe, .ctlPinZero, .ctlPinOne, .ctlPinTwo, .addrStrobeIn, .busMode,
      .muxedBus, .strobeRising, .codeFetchEn, .segEn, .segBase, .segMask, .segTarget, .segProgSpace,
      .inAppProgramming, .reclassToData, .secondaryRemoveEn, .updateDone, .memAddr, .memWdata, .memSel,
      .memRead, .memWrite, .memRdata, .pldAddr, .pldCtl, .pldGeneric, .codeFetch, .blockReset, .flashAbort);
   mbhp_host_model i_host (.clk_sys, .devOut(lowBusByteOut), .devOe(lowBusByteOe), .lowLane(lowBusByteIn),
      .highLane(highBusByteIn), .wrN(ctlPinZero), .rdN(ctlPinOne), .fetchN(ctlPinTwo), .ale(addrStrobeIn));
   ////////////////////////////////////////
   always @(posedge clk_sys) begin
      cycles++;
      if (memRead === 1'b1) nRead++;
      if (memWrite === 1'b1) nWrite++;
      if (lowBusByteOe === 1'b1) nOe++;
      if (memRead === 1'b1 || memWrite === 1'b1) pulseSel = memSel;
      if (cycles == 4000) begin
         nMismatch++;
         closeOut();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic closeOut();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : closeOut
   ////////////////////////////////////////
   task automatic runCycle(input string nm, input logic wr, input logic fetch, input logic [ADDR_W-1:0] a,
      input logic [LANE_W-1:0] d, input logic [NUM_TGT-1:0] expSel);
      logic [LANE_W-1:0] rd;
      nRead = 0;
      nWrite = 0;
      nOe = 0;
      pulseSel = 3'h0;
      i_host.hostCycle(wr, fetch, a, d, rd);
      repeat (4) @(posedge clk_sys);
      check({nm, " pulses"}, 16'(wr ? nWrite : nRead), {15'h0, expSel != 3'h0});
      check({nm, " select"}, {13'h0, pulseSel}, {13'h0, expSel});
      check({nm, " lane drive"}, {15'h0, nOe > 0}, {15'h0, !wr && expSel != 3'h0});
      if (expSel != 3'h0) begin
         check({nm, " address"}, pldAddr, a);
         check({nm, " data"}, {8'h0, wr ? memWdata : rd}, {8'h0, wr ? d : a[7:0] ^ 8'h5a});
      end
   endtask : runCycle

   task automatic testReset();
      repeat (8) @(posedge clk_sys);
      check("block reset", {15'h0, blockReset}, 16'h1);
      check("flash abort", {15'h0, flashAbort}, 16'h1);
      check("lane enable", {15'h0, lowBusByteOe}, 16'h0);
      check("ctl mirror", {13'h0, pldCtl}, 16'h7);
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("abort end", {15'h0, flashAbort}, 16'h0);
      check("upper lane", {7'h0, highBusByteOe, highBusByteOut}, 16'h0);
      $display("reset test done");
   endtask : testReset

   task automatic testSram();
      runCycle("sram write", 1'b1, 1'b0, 16'h8012, 8'ha7, 3'h4);
      runCycle("sram read", 1'b0, 1'b0, 16'h8034, 8'h00, 3'h4);
      runCycle("miss read", 1'b0, 1'b0, 16'hc000, 8'h00, 3'h0);
      $display("sram test done");
   endtask : testSram

   task automatic testFetch();
      runCycle("code fetch", 1'b0, 1'b1, 16'h0100, 8'h00, 3'h1);
      runCycle("second read", 1'b0, 1'b0, 16'h4010, 8'h00, 3'h2);
      runCycle("prog write", 1'b1, 1'b0, 16'h0200, 8'h33, 3'h0);
      @(posedge clk_sys);
      inAppProgramming <= 1'b1;
      reclassToData <= 1'b1;
      runCycle("iap write", 1'b1, 1'b0, 16'h0200, 8'h33, 3'h1);
      @(posedge clk_sys);
      inAppProgramming <= 1'b0;
      reclassToData <= 1'b0;
      $display("fetch test done");
   endtask : testFetch

   task automatic testRemove();
      @(posedge clk_sys);
      secondaryRemoveEn <= 1'b1;
      updateDone <= 1'b1;
      runCycle("removed read", 1'b0, 1'b0, 16'h4010, 8'h00, 3'h0);
      $display("remove test done");
   endtask : testRemove

   // mode inputs change only while the host pins are idle
   task automatic testModes();
      @(posedge clk_sys);
      busMode <= MODE_FETCH_RD;
      runCycle("fetch as read", 1'b0, 1'b0, 16'h0120, 8'h00, 3'h1);
      @(posedge clk_sys);
      busMode <= MODE_RW_DATASTB;
      runCycle("strobed read", 1'b0, 1'b0, 16'h8056, 8'h00, 3'h4);
      @(posedge clk_sys);
      busMode <= MODE_WR_RD;
      strobeRising <= 1'b1;
      runCycle("rising latch", 1'b0, 1'b0, 16'h8078, 8'h00, 3'h4);
      runCycle("code as data", 1'b0, 1'b0, 16'h0120, 8'h00, 3'h0);
      @(posedge clk_sys);
      strobeRising <= 1'b0;
      codeFetchEn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check("generic input", {15'h0, pldGeneric}, 16'h1);
      runCycle("fetch ignored", 1'b0, 1'b1, 16'h0100, 8'h00, 3'h0);
      @(posedge clk_sys);
      codeFetchEn <= 1'b1;
      muxedBus <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("plain address", {8'h0, pldAddr[15:8]}, {8'h0, highBusByteIn});
      $display("modes test done");
   endtask : testModes

   initial begin
      testReset();
      testSram();
      testFetch();
      testRemove();
      testModes();
      closeOut();
   end
endmodule : mbhp_host_port_tb_top
